// ===== design/eic_regs.svh
`ifndef EIC_REGS_SVH
`define EIC_REGS_SVH

// register indices as printed; byte address is four times the index
`define NMI_CTRL_IDX 8'h02
`define NMI_FLAG_IDX 8'h03
`define EVOUT_IDX 8'h04
`define IEN_CLR_IDX 8'h08
`define IEN_SET_IDX 8'h0C
`define LFLAG_IDX 8'h10
`define CFG0_IDX 8'h18
`define CFG1_IDX 8'h1C
`define WPROT_IDX 8'h20
`define NMI_IMASK_IDX 8'h21

// field positions
`define NMI_FILT_BIT 3
`define SENSE_W 3
`define CFG_FIELD_W 4

// reset values
`define NMI_CTRL_RST 8'h00
`define LINE_RST 16'h0000
`define CFG_RST 32'h0000_0000

// glitch filter: input must stand this many cycles
`define FILT_LEN 3

`endif

// ===== design/eic_pkg.sv
package eic_pkg;
  typedef enum logic [2:0] {
    SENSE_NONE = 3'b000,
    SENSE_RISE = 3'b001,
    SENSE_FALL = 3'b010,
    SENSE_BOTH = 3'b011,
    SENSE_HIGH = 3'b100,
    SENSE_LOW = 3'b101
  } sense_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;
endpackage

// ===== design/line_detect.sv
`timescale 1ns/100ps
`include "eic_regs.svh"
// one input line: synchroniser, optional glitch filter, trigger match
module line_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and configuration
  input wire logic pin,
  input wire logic filter_on,
  input wire logic [2:0] trigger_select,
  // detection
  output logic match
);
  logic sync1_q;
  logic sync2_q;
  logic [1:0] cnt_q;
  logic filt_q;
  logic prev_q;
  logic level;
  logic rise;
  logic fall;
  logic [1:0] cnt_d;

  // two stages before any logic looks at the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // filter counts consecutive disagreeing samples; short pulses never reach filt_q
  assign cnt_d = (sync2_q == filt_q) ? 2'h0 : cnt_q + 2'h1;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
      filt_q <= 1'b0;
    end else if (cnt_d == 2'(`FILT_LEN)) begin
      cnt_q <= 2'h0;
      filt_q <= sync2_q;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // filter bypass selects raw synchronised level
  assign level = filter_on ? filt_q : sync2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

  // reserved codes detect nothing
  always_comb begin
    case (trigger_select)
      eic_pkg::SENSE_RISE: match = rise;
      eic_pkg::SENSE_FALL: match = fall;
      eic_pkg::SENSE_BOTH: match = rise | fall;
      eic_pkg::SENSE_HIGH: match = level;
      eic_pkg::SENSE_LOW: match = ~level;
      default: match = 1'b0;
    endcase
  end
endmodule

// ===== design/eic_core.sv
`timescale 1ns/100ps
`include "eic_regs.svh"
module eic_core #(
  parameter int LINES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic nonmaskable_pin,
  input wire logic [LINES-1:0] external_line,
  // outputs to processor and event system
  output logic nonmaskable_irq,
  output logic line_irq,
  output logic [LINES-1:0] line_event
);
  // register state
  logic [7:0] nmi_ctrl_q;
  logic nmi_flag_q;
  logic nmi_imask_q;
  logic [LINES-1:0] evout_q;
  logic [LINES-1:0] ien_q;
  logic [LINES-1:0] lflag_q;
  logic [31:0] cfg0_q;
  logic [31:0] cfg1_q;
  logic wprot_q;

  // bus state
  logic aw_full_q;
  logic [7:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  eic_pkg::rd_state_t rd_state_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // output flops
  logic nmi_irq_q;
  logic line_irq_q;
  logic [LINES-1:0] event_q;

  // write channel: each side is captured separately so order does not matter
  wire aw_take = s_axi_awvalid & ~aw_full_q;
  wire w_take = s_axi_wvalid & ~w_full_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire [5:0] widx = aw_addr_q[7:2];
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wval = w_data_q & wmask;

  wire hit_nmictl_w = (widx == 6'(`NMI_CTRL_IDX));
  wire hit_nmiflg_w = (widx == 6'(`NMI_FLAG_IDX));
  wire hit_evout_w = (widx == 6'(`EVOUT_IDX));
  wire hit_iclr_w = (widx == 6'(`IEN_CLR_IDX));
  wire hit_iset_w = (widx == 6'(`IEN_SET_IDX));
  wire hit_lflag_w = (widx == 6'(`LFLAG_IDX));
  wire hit_cfg0_w = (widx == 6'(`CFG0_IDX));
  wire hit_cfg1_w = (widx == 6'(`CFG1_IDX));
  wire hit_wprot_w = (widx == 6'(`WPROT_IDX));
  wire hit_imask_w = (widx == 6'(`NMI_IMASK_IDX));
  wire w_mapped = hit_nmictl_w | hit_nmiflg_w | hit_evout_w | hit_iclr_w | hit_iset_w
    | hit_lflag_w | hit_cfg0_w | hit_cfg1_w | hit_wprot_w | hit_imask_w;
  // protected registers silently drop writes while protection is on
  wire wr_ok = do_write & ~wprot_q;
  wire [LINES-1:0] wl = wval[LINES-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (aw_take) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (w_take) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  // unmapped address gets slverr
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_mapped ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // protected configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_ctrl_q <= `NMI_CTRL_RST;
      evout_q <= `LINE_RST;
      ien_q <= `LINE_RST;
      cfg0_q <= `CFG_RST;
      cfg1_q <= `CFG_RST;
    end else if (wr_ok) begin
      if (hit_nmictl_w) nmi_ctrl_q <= {4'h0, wval[3:0]};
      if (hit_evout_w) evout_q <= wl;
      if (hit_iclr_w) ien_q <= ien_q & ~wl;
      if (hit_iset_w) ien_q <= ien_q | wl;
      if (hit_cfg0_w) cfg0_q <= wval;
      if (hit_cfg1_w) cfg1_q <= wval;
    end
  end

  // unprotected control: protection switch and nmi_imask_q, which is stored and read back but gates no output
  always_ff @(posedge clk) begin
    if (rst) begin
      wprot_q <= 1'b0;
      nmi_imask_q <= 1'b1;
    end else if (do_write) begin
      if (hit_wprot_w) wprot_q <= wval[0];
      if (hit_imask_w) nmi_imask_q <= wval[0];
    end
  end

  // detectors
  logic nmi_match;
  logic [LINES-1:0] line_match;
  wire [63:0] cfg_all = {cfg1_q, cfg0_q};

  line_detect nmi_det (
    .clk(clk),
    .rst(rst),
    .pin(nonmaskable_pin),
    .filter_on(nmi_ctrl_q[`NMI_FILT_BIT]),
    .trigger_select(nmi_ctrl_q[2:0]),
    .match(nmi_match)
  );

  // line index is register number times eight plus field position
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      line_detect det (
        .clk(clk),
        .rst(rst),
        .pin(external_line[g]),
        .filter_on(cfg_all[g*`CFG_FIELD_W+3]),
        .trigger_select(cfg_all[g*`CFG_FIELD_W +: `SENSE_W]),
        .match(line_match[g])
      );
    end
  endgenerate

  // flags: a match in the same cycle as a clear keeps the flag set
  wire nmi_clr = do_write & hit_nmiflg_w & wval[0];
  wire [LINES-1:0] lclr = (do_write & hit_lflag_w) ? wl : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_flag_q <= 1'b0;
      lflag_q <= `LINE_RST;
    end else begin
      nmi_flag_q <= nmi_match | (nmi_flag_q & ~nmi_clr);
      lflag_q <= line_match | (lflag_q & ~lclr);
    end
  end

  // interrupt and event outputs, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_irq_q <= 1'b0;
      line_irq_q <= 1'b0;
      event_q <= `LINE_RST;
    end else begin
      // no enable of any kind may hold back the nonmaskable request
      nmi_irq_q <= nmi_flag_q;
      line_irq_q <= |(lflag_q & ien_q);
      event_q <= line_match & evout_q;
    end
  end

  // read path: one read at a time, answered the cycle after the address
  wire [5:0] ridx = s_axi_araddr[7:2];
  wire ar_take = s_axi_arvalid & (rd_state_q == eic_pkg::RD_IDLE);
  wire [31:0] ien_rd = {{(32-LINES){1'b0}}, ien_q};
  wire hit_nmictl_r = (ridx == 6'(`NMI_CTRL_IDX));
  wire hit_nmiflg_r = (ridx == 6'(`NMI_FLAG_IDX));
  wire hit_evout_r = (ridx == 6'(`EVOUT_IDX));
  wire hit_ien_r = (ridx == 6'(`IEN_CLR_IDX)) | (ridx == 6'(`IEN_SET_IDX));
  wire hit_lflag_r = (ridx == 6'(`LFLAG_IDX));
  wire hit_cfg0_r = (ridx == 6'(`CFG0_IDX));
  wire hit_cfg1_r = (ridx == 6'(`CFG1_IDX));
  wire hit_wprot_r = (ridx == 6'(`WPROT_IDX));
  wire hit_imask_r = (ridx == 6'(`NMI_IMASK_IDX));
  wire [31:0] rd_val =
    hit_nmictl_r ? {24'h000000, nmi_ctrl_q} :
    hit_nmiflg_r ? {31'h0, nmi_flag_q} :
    hit_evout_r ? {{(32-LINES){1'b0}}, evout_q} :
    hit_ien_r ? ien_rd :
    hit_lflag_r ? {{(32-LINES){1'b0}}, lflag_q} :
    hit_cfg0_r ? cfg0_q :
    hit_cfg1_r ? cfg1_q :
    hit_wprot_r ? {31'h0, wprot_q} :
    hit_imask_r ? {31'h0, nmi_imask_q} : 32'h0000_0000;
  wire r_mapped = hit_nmictl_r | hit_nmiflg_r | hit_evout_r | hit_ien_r | hit_lflag_r
    | hit_cfg0_r | hit_cfg1_r | hit_wprot_r | hit_imask_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_state_q <= eic_pkg::RD_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else begin
      case (rd_state_q)
        eic_pkg::RD_IDLE: begin
          if (ar_take) begin
            rd_state_q <= eic_pkg::RD_RESP;
            rdata_q <= rd_val;
            rresp_q <= r_mapped ? 2'h0 : 2'h2;
          end
        end
        eic_pkg::RD_RESP: begin
          if (s_axi_rready) rd_state_q <= eic_pkg::RD_IDLE;
        end
        default: rd_state_q <= eic_pkg::RD_IDLE;
      endcase
    end
  end

  // ready flags reflect empty holding stages, so they stand until taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= ~(aw_full_q | aw_take) | do_write;
      s_axi_wready <= ~(w_full_q | w_take) | do_write;
      s_axi_arready <= (rd_state_q == eic_pkg::RD_IDLE) & ~ar_take
        | (rd_state_q == eic_pkg::RD_RESP) & s_axi_rready;
    end
  end

  // remaining outputs straight from flops
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = (rd_state_q == eic_pkg::RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign nonmaskable_irq = nmi_irq_q;
  assign line_irq = line_irq_q;
  assign line_event = event_q;
endmodule

// ===== tb/eic_core_asserts.sv
`timescale 1ns/100ps
module eic_core_asserts #(
  parameter int LINES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // requests and events
  input wire logic nonmaskable_irq,
  input wire logic line_irq,
  input wire logic [LINES-1:0] line_event
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // answers stand until the master takes them
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  // read answer comes one cycle after the address is taken
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read response repeated");
  // no second read while one is still answered, and no second write address in the cycle after one is taken
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while pending");
  property p_awblk; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_awblk: assert property (p_awblk) else $error("write taken while pending");
  // nothing requested straight out of reset
  property p_rst; $fell(rst) |-> !line_irq && !nonmaskable_irq && line_event == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("request out of reset");
endmodule

bind eic_core eic_core_asserts #(.LINES(LINES)) u_chk (.*);

// ===== tb/pin_model.sv
`timescale 1ns/100ps
// board side of the pins; levels change just after clock edges
module pin_model #(
  parameter int LINES = 16
) (
  // clock
  input wire logic clk,
  // pins
  output logic nonmaskable_pin,
  output logic [LINES-1:0] external_line
);
  // pins idle low; no pull, so they are always driven
  initial begin
    nonmaskable_pin = 1'h0;
    external_line = '0;
  end
  // a pulse of w cycles, short ones probe the filter
  task automatic nmi_pulse(input int w);
    @(posedge clk);
    nonmaskable_pin <= 1'h1;
    repeat (w) @(posedge clk);
    nonmaskable_pin <= 1'h0;
  endtask
  // one line to a level
  task automatic line_set(input int i, input logic v);
    @(posedge clk);
    external_line[i] <= v;
  endtask
endmodule

// ===== tb/external_irq_flag_enable_logic_tb.sv
`timescale 1ns/100ps
module external_irq_flag_enable_logic_tb;
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  logic clk = 1'h0, rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic nonmaskable_pin, nonmaskable_irq, line_irq;
  logic [15:0] external_line, line_event;
  logic [7:0] nm_exp = 8'h3E;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  // 250 MHz
  always #2 clk = ~clk;
  eic_core dut (.*);
  pin_model pins (.*);
  task summarize;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize;
    end
  end
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask
  task t_reset;
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h0);
    rd(8'hFC, 32'h0, 2'h2);
    $display("test reset done");
  endtask
  // set and clear share one enable state
  task t_enable;
    wr(8'h30, 32'hF0, 2'h0);
    rd(8'h20, 32'hF0, 2'h0);
    wr(8'h20, 32'h30, 2'h0);
    rd(8'h30, 32'hC0, 2'h0);
    $display("test enable done");
  endtask
  // flag sets with enable off, request follows the enable
  task t_line;
    wr(8'h60, 32'h41, 2'h0);
    pins.line_set(0, 1'h1);
    repeat (10) @(posedge clk);
    rd(8'h40, 32'h1, 2'h0);
    `CHK(line_irq, 1'h0)
    wr(8'h30, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    `CHK(line_irq, 1'h1)
    wr(8'h40, 32'h0, 2'h0);
    rd(8'h40, 32'h1, 2'h0);
    wr(8'h40, 32'h1, 2'h0);
    rd(8'h40, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    `CHK(line_irq, 1'h0)
    pins.line_set(0, 1'h0);
    $display("test line done");
  endtask
  // level trigger keeps firing only the enabled event
  task t_event;
    wr(8'h10, 32'h2, 2'h0);
    pins.line_set(1, 1'h1);
    pins.line_set(0, 1'h1);
    repeat (10) @(posedge clk);
    `CHK(line_event, 16'h0002)
    pins.line_set(1, 1'h0);
    pins.line_set(0, 1'h0);
    wr(8'h40, 32'hFFFF, 2'h0);
    $display("test event done");
  endtask
  // every trigger code, then clear
  task t_nmi;
    for (int c = 0; c < 8; c++) begin
      wr(8'h08, 32'(c), 2'h0);
      pins.nmi_pulse(6);
      repeat (10) @(posedge clk);
      wr(8'h08, 32'h0, 2'h0);
      rd(8'h0C, {31'h0, nm_exp[c]}, 2'h0);
      `CHK(nonmaskable_irq, nm_exp[c])
      wr(8'h0C, 32'h1, 2'h0);
      rd(8'h0C, 32'h0, 2'h0);
    end
    $display("test nmi done");
  endtask
  // a two-cycle glitch passes only with the filter off
  task t_filter;
    wr(8'h08, 32'h9, 2'h0);
    pins.nmi_pulse(2);
    repeat (12) @(posedge clk);
    rd(8'h0C, 32'h0, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    pins.nmi_pulse(2);
    repeat (12) @(posedge clk);
    rd(8'h0C, 32'h1, 2'h0);
    wr(8'h0C, 32'h1, 2'h0);
    $display("test filter done");
  endtask
  task t_protect;
    wr(8'h80, 32'h1, 2'h0);
    wr(8'h30, 32'hFFFF, 2'h0);
    rd(8'h30, 32'hC1, 2'h0);
    wr(8'h80, 32'h0, 2'h0);
    $display("test protect done");
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset;
    t_enable;
    t_line;
    t_event;
    t_nmi;
    t_filter;
    t_protect;
    summarize;
  end
endmodule
